// *** eci_pkg.sv ***
// Package: register map, field layout and carrier types for encoder control
package eci_pkg;
	localparam int          ECI_NCH      = 4;
	localparam int          ECI_NDIN     = 8;
	localparam int          ECI_CW       = 24;
	// Register byte offsets
	localparam logic [11:0] ECI_CTRL_OFS = 12'h000; // +0x10 per channel
	localparam logic [11:0] ECI_PRE_OFS  = 12'h004;
	localparam logic [11:0] ECI_MAT_OFS  = 12'h008;
	localparam logic [11:0] ECI_CNT_OFS  = 12'h00C;
	localparam logic [11:0] ECI_LAT_OFS  = 12'h040; // +0x4 per channel
	localparam logic [11:0] ECI_DIN_OFS  = 12'h050;
	localparam logic [11:0] ECI_STS_OFS  = 12'h054;
	localparam logic [11:0] ECI_MSK_OFS  = 12'h058;
	localparam logic [11:0] ECI_SWT_OFS  = 12'h05C;
	localparam logic [11:0] ECI_MAP_END  = 12'h060;
	// Control word fields
	localparam int          ECI_F_MODE   = 0;  // two bits
	localparam int          ECI_F_CHEN   = 2;
	localparam int          ECI_F_MEN    = 3;
	localparam int          ECI_F_IDXEN  = 4;
	localparam int          ECI_F_IOM    = 5;
	localparam int          ECI_F_PRIDX  = 6;
	localparam int          ECI_F_CAPEN  = 7;
	localparam int          ECI_CTRL_W   = 8;
	localparam logic [7:0]  ECI_CTRL_RST = 8'h00;
	localparam logic [23:0] ECI_PRE_RST  = 24'h0001F3;
	localparam logic [23:0] ECI_CNT_MAX  = 24'hFFFFFF;
	localparam logic [23:0] ECI_CNT_ZERO = 24'h000000;
	localparam logic [31:0] ECI_RD_ZERO  = 32'h00000000;

	typedef enum logic [1:0] {
		ECI_MODE_FREE,
		ECI_MODE_RANGE,
		ECI_MODE_NOREC,
		ECI_MODE_MODN
	} eci_mode_t;

	typedef struct packed {
		logic [ECI_CTRL_W-1:0] ctrl;
		logic [ECI_CW-1:0]     preset;
		logic [ECI_CW-1:0]     match;
		logic                  armed;
	} eci_cfg_t;

	typedef struct packed {
		logic [1:0] ab;
		logic       idx;
	} eci_enc_t;

	// Channel counter state
	typedef struct packed {
		logic [ECI_CW-1:0] count;
		logic [ECI_CW-1:0] latch;
		logic [1:0]        ab_q;
		logic              idx_q;
		logic              armed;
		logic              match_q;
		logic              match_p;
		logic              idx_p;
	} eci_ch_t;
endpackage : eci_pkg

// *** eci_chan.sv ***
// One encoder channel: x4 quadrature counter, modes, index, match, capture
`timescale 1ns/100ps
`default_nettype none
module eci_chan
	import eci_pkg::*;
(
	input  wire logic                  pclk,      // System clock
	input  wire logic                  presetn,   // Async reset, low
	input  wire eci_enc_t              enc,       // Encoder pins
	input  wire logic [ECI_CTRL_W-1:0] ctrl,      // Control word
	input  wire logic [ECI_CW-1:0]     preset,    // Preset value
	input  wire logic [ECI_CW-1:0]     match,     // Match value
	input  wire logic                  ld,        // Software count load
	input  wire logic [ECI_CW-1:0]     ld_val,    // Load value
	input  wire logic                  trig_ext,  // Pin or software trigger
	output logic      [ECI_CW-1:0]     count,     // Counter value
	output logic      [ECI_CW-1:0]     latch,     // Output latch
	output logic                       match_ev,  // Match event pulse
	output logic                       idx_ev     // Index acted pulse
);
	eci_ch_t s;
	eci_ch_t next_s;

	// One quadrature step: +1, -1 or 0 from old/new AB state
	function automatic logic [1:0] eci_dir(input logic [1:0] o,
		input logic [1:0] n);
		logic fwd;
		fwd = (o == 2'h0 && n == 2'h1) || (o == 2'h1 && n == 2'h3) ||
			(o == 2'h3 && n == 2'h2) || (o == 2'h2 && n == 2'h0);
		if (o == n || (o ^ n) == 2'h3)
			eci_dir = 2'h0;
		else if (fwd)
			eci_dir = 2'h1;
		else
			eci_dir = 2'h2;
	endfunction

	// Next counter state
	always_comb
	begin
		logic [1:0]        d;
		logic [ECI_CW-1:0] c;
		logic              run;
		logic              idx_rise;
		logic              idx_live;
		logic [ECI_CW-1:0] lim;
		d = eci_dir(s.ab_q, enc.ab);
		c = s.count;
		run = ctrl[ECI_F_CHEN] && ctrl[ECI_F_MEN];
		lim = preset;
		idx_rise = enc.idx && !s.idx_q;
		idx_live = 1'b0;
		next_s = s;
		next_s.ab_q = enc.ab;
		next_s.idx_q = enc.idx;
		next_s.match_p = 1'b0;
		next_s.idx_p = 1'b0;
		if (run && d == 2'h1)
		begin
			unique case (eci_mode_t'(ctrl[ECI_F_MODE +: 2]))
				ECI_MODE_FREE:  c = s.count + 24'h000001;
				ECI_MODE_RANGE: c = (s.count >= lim) ? lim
					: s.count + 24'h000001;
				ECI_MODE_NOREC: c = (s.count == ECI_CNT_MAX) ? s.count
					: s.count + 24'h000001;
				ECI_MODE_MODN:  c = (s.count >= lim) ? ECI_CNT_ZERO
					: s.count + 24'h000001;
			endcase
		end
		else if (run && d == 2'h2)
		begin
			unique case (eci_mode_t'(ctrl[ECI_F_MODE +: 2]))
				ECI_MODE_FREE:  c = s.count - 24'h000001;
				ECI_MODE_RANGE: c = (s.count == ECI_CNT_ZERO) ? s.count
					: s.count - 24'h000001;
				ECI_MODE_NOREC: c = (s.count == ECI_CNT_ZERO) ? s.count
					: s.count - 24'h000001;
				ECI_MODE_MODN:  c = (s.count == ECI_CNT_ZERO) ? lim
					: s.count - 24'h000001;
			endcase
		end
		// Match compare and arming
		next_s.match_q = (s.count == match);
		if (s.count == match && !s.match_q)
			next_s.match_p = 1'b1;
		if (!ctrl[ECI_F_IOM])
			next_s.armed = 1'b0;
		else if (s.count == match)
			next_s.armed = 1'b1;
		idx_live = ctrl[ECI_F_IOM] ? s.armed : ctrl[ECI_F_IDXEN];
		if (idx_rise && idx_live && run)
		begin
			c = ctrl[ECI_F_PRIDX] ? preset : ECI_CNT_ZERO;
			next_s.idx_p = 1'b1;
			if (ctrl[ECI_F_IOM])
				next_s.armed = 1'b0;
		end
		if (ld)
			c = ld_val;
		next_s.count = c;
		// Capture on any trigger
		if (ctrl[ECI_F_CAPEN] && (trig_ext || s.match_p))
			next_s.latch = s.count;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign count = s.count;
	assign latch = s.latch;
	assign match_ev = s.match_p;
	assign idx_ev = s.idx_p;

	// Counter frozen while master enable is low
	hold_cnt_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl[ECI_F_MEN] && !ld |=> $stable(s.count))
		else $error("count moved with enable low");
	dis_ch_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl[ECI_F_CHEN] && !ld |=> $stable(s.count))
		else $error("disabled channel counted");
	free_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl[1:0] == 2'h0 && ctrl[ECI_F_CHEN] && ctrl[ECI_F_MEN] && !ld &&
		s.count == ECI_CNT_MAX && eci_dir(s.ab_q, enc.ab) == 2'h1 &&
		!(enc.idx && !s.idx_q) |=> s.count == ECI_CNT_ZERO)
		else $error("free counter did not wrap");
	norec_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl[1:0] == 2'h2 && s.count == ECI_CNT_MAX && !ld &&
		eci_dir(s.ab_q, enc.ab) != 2'h2 &&
		!(enc.idx && !s.idx_q) |=> s.count == ECI_CNT_MAX)
		else $error("non-recycle counter wrapped");
	modn_roll_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl[1:0] == 2'h3 && ctrl[ECI_F_CHEN] && ctrl[ECI_F_MEN] && !ld &&
		s.count == preset && eci_dir(s.ab_q, enc.ab) == 2'h1 &&
		!(enc.idx && !s.idx_q) |=> s.count == ECI_CNT_ZERO)
		else $error("modulo-N did not roll");
	match_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl[ECI_F_IOM] && s.count == match |=> s.armed || s.idx_p)
		else $error("match did not arm index");
	idx_disarm_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl[ECI_F_IOM] && s.idx_p && $past(s.count) != match
		|-> !s.armed)
		else $error("index left detection armed");
	match_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		s.match_p |-> $past(s.count) == $past(match))
		else $error("match pulse without equality");
	cap_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl[ECI_F_CAPEN] |=> $stable(s.latch))
		else $error("latch changed with capture off");
endmodule // eci_chan
`default_nettype wire

// *** eci_top.sv ***
// Four-channel encoder counter with index, match and input triggers on APB
//
// Functional notes
// - Mode 1: preset acts as upper range limit.
// - Mode 2: counter stops at ends instead of wrapping.
// - Mode 3: modulo-N counter, N from preset.
// - Each of four channels has its own on/off enable.
// - Counter changes only while master count enable is set; a software count load changes it regardless.
// - Index acts only while index detection enabled, per preset-on-index.
// - With match-armed indexing, equality with match arms index detection.
// - Armed index resets or presets counter, then disarms until next match.
// - Without match-armed indexing, index follows ordinary index enable.
// - Each of eight input pins has a trigger enable.
// - Per-pin edge select: set means rising, clear means falling.
// - Capture enabled: any trigger copies counter into output latch.
// - Match trigger once each time counter becomes equal to 24-bit match value.
`timescale 1ns/100ps
`default_nettype none
module eci_top
	import eci_pkg::*;
(
	input  wire logic                pclk,     // APB clock, 50 MHz
	input  wire logic                presetn,  // Async reset, low
	input  wire logic                psel,     // APB select
	input  wire logic                penable,  // APB enable
	input  wire logic                pwrite,   // APB direction
	input  wire logic [11:0]         paddr,    // APB byte address
	input  wire logic [31:0]         pwdata,   // APB write data
	output logic      [31:0]         prdata,   // APB read data
	output logic                     pready,   // APB ready
	output logic                     pslverr,  // APB error
	input  wire eci_enc_t [ECI_NCH-1:0] enc,   // Encoder A/B/index pins
	input  wire logic [ECI_NDIN-1:0] din,      // Digital trigger pins
	output logic                     irq,      // Interrupt, high active
	output logic      [ECI_NCH-1:0]  trig_out  // Per-channel trigger pulse
);
	typedef struct packed {
		eci_cfg_t [ECI_NCH-1:0] cfg;
		logic [ECI_NDIN-1:0]    din_en;
		logic [ECI_NDIN-1:0]    din_rise;
		logic [ECI_NDIN-1:0]    sync1;
		logic [ECI_NDIN-1:0]    sync2;
		logic [ECI_NDIN-1:0]    sync3;
		logic [ECI_NDIN-1:0]    pin_trig;
		logic [15:0]            sts;
		logic [15:0]            msk;
		logic [ECI_NCH-1:0]     ld;
		logic [ECI_CW-1:0]      ld_val;
		logic [ECI_NCH-1:0]     sw_trig;
		logic [31:0]            rdata;
		logic                   ready;
		logic                   slverr;
		logic                   irq;
		logic [ECI_NCH-1:0]     tout;
	} eci_top_t;

	eci_top_t r;
	eci_top_t next_r;

	logic [ECI_NCH-1:0][ECI_CW-1:0] cnt;
	logic [ECI_NCH-1:0][ECI_CW-1:0] lat;
	logic [ECI_NCH-1:0]             m_ev;
	logic [ECI_NCH-1:0]             i_ev;
	logic [ECI_NCH-1:0]             trig_any;

	// Any pin trigger feeds every channel's capture; software trigger bit i feeds channel i only
	always_comb
	begin
		for (int i = 0; i < ECI_NCH; i++)
			trig_any[i] = (|r.pin_trig) || r.sw_trig[i];
	end

	generate
		for (genvar g = 0; g < ECI_NCH; g++)
		begin : g_ch
			eci_chan u_ch (
				.pclk     (pclk),
				.presetn  (presetn),
				.enc      (enc[g]),
				.ctrl     (r.cfg[g].ctrl),
				.preset   (r.cfg[g].preset),
				.match    (r.cfg[g].match),
				.ld       (r.ld[g]),
				.ld_val   (r.ld_val),
				.trig_ext (trig_any[g]),
				.count    (cnt[g]),
				.latch    (lat[g]),
				.match_ev (m_ev[g]),
				.idx_ev   (i_ev[g])
			);
		end
	endgenerate

	// Channel index of a per-channel register, from the address
	function automatic logic [1:0] eci_chsel(input logic [11:0] a);
		eci_chsel = a[5:4];
	endfunction

	// Word within a channel group
	function automatic logic [11:0] eci_word(input logic [11:0] a);
		eci_word = {8'h00, a[3:0]};
	endfunction

	// Registers, pin triggers, APB slave and interrupt
	always_comb
	begin
		logic       acc;
		logic       wr;
		logic [1:0] ch;
		logic [15:0] ev;
		next_r = r;
		acc = psel && !penable;
		wr = acc && pwrite;
		ch = eci_chsel(paddr);
		ev = {8'h00, i_ev, m_ev};
		next_r.ld = '0;
		next_r.sw_trig = '0;
		next_r.ready = 1'b0;
		next_r.slverr = 1'b0;
		// Two-flop sync, third flop for edge compare
		next_r.sync1 = din;
		next_r.sync2 = r.sync1;
		next_r.sync3 = r.sync2;
		next_r.pin_trig = r.din_en &
			((r.sync2 & ~r.sync3 & r.din_rise) |
			(~r.sync2 & r.sync3 & ~r.din_rise));
		next_r.tout = m_ev;
		// Setup cycle decodes; answer comes in the access cycle
		if (acc)
		begin
			next_r.ready = 1'b1;
			next_r.rdata = ECI_RD_ZERO;
			if (paddr[1:0] != 2'h0 || paddr >= ECI_MAP_END)
				next_r.slverr = 1'b1;
			else if (paddr < ECI_LAT_OFS)
			begin
				unique case (eci_word(paddr))
					ECI_CTRL_OFS:
					begin
						next_r.rdata = {24'h000000, r.cfg[ch].ctrl};
						// Full word write; mode-only changes rely on
						// software read-modify-write of this word.
						if (wr)
							next_r.cfg[ch].ctrl = pwdata[ECI_CTRL_W-1:0];
					end
					ECI_PRE_OFS:
					begin
						next_r.rdata = {8'h00, r.cfg[ch].preset};
						if (wr)
							next_r.cfg[ch].preset = pwdata[ECI_CW-1:0];
					end
					ECI_MAT_OFS:
					begin
						next_r.rdata = {8'h00, r.cfg[ch].match};
						if (wr)
							next_r.cfg[ch].match = pwdata[ECI_CW-1:0];
					end
					ECI_CNT_OFS:
					begin
						next_r.rdata = {8'h00, cnt[ch]};
						if (wr)
						begin
							next_r.ld[ch] = 1'b1;
							next_r.ld_val = pwdata[ECI_CW-1:0];
						end
					end
					default: next_r.slverr = 1'b1;
				endcase
			end
			else if (paddr < ECI_DIN_OFS)
				next_r.rdata = {8'h00, lat[paddr[3:2]]};
			else
			begin
				unique case (paddr)
					ECI_DIN_OFS:
					begin
						next_r.rdata = {16'h0000, r.din_rise, r.din_en};
						if (wr)
						begin
							next_r.din_en = pwdata[7:0];
							next_r.din_rise = pwdata[15:8];
						end
					end
					ECI_STS_OFS: next_r.rdata = {16'h0000, r.sts};
					ECI_MSK_OFS:
					begin
						next_r.rdata = {16'h0000, r.msk};
						if (wr)
							next_r.msk = pwdata[15:0];
					end
					ECI_SWT_OFS:
						if (wr)
							next_r.sw_trig = pwdata[ECI_NCH-1:0];
					default: next_r.slverr = 1'b1;
				endcase
			end
		end
		// Sticky events: write one clears, a new event wins
		if (wr && paddr == ECI_STS_OFS)
			next_r.sts = r.sts & ~pwdata[15:0];
		next_r.sts = next_r.sts | ev;
		next_r.irq = |(next_r.sts & next_r.msk);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r <= '0;
			for (int i = 0; i < ECI_NCH; i++)
				r.cfg[i].preset <= ECI_PRE_RST;
		end
		else
			r <= next_r;
	end

	assign prdata = r.rdata;
	assign pready = r.ready;
	assign pslverr = r.slverr;
	assign irq = r.irq;
	assign trig_out = r.tout;

	// Pin trigger is a single pulse per edge
	pin_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		r.pin_trig[0] |=> !r.pin_trig[0])
		else $error("pin trigger longer than one cycle");
	pin_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		!r.din_en[0] |=> !r.pin_trig[0])
		else $error("disabled pin fired");
	pin_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
		r.pin_trig[0] |-> $past(r.sync2[0]) == $past(r.din_rise[0]))
		else $error("pin fired on wrong edge");
	sts_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
		r.sts[0] && !(psel && !penable && pwrite) |=> r.sts[0])
		else $error("status bit lost");
endmodule // eci_top
`default_nettype wire

// *** eci_enc_model.sv ***
// Encoder and trigger-pin stimulus model for the counter block
`timescale 1ns/100ps
`default_nettype none
module eci_enc_model
	import eci_pkg::*;
(
	input  wire logic                  pclk, // System clock
	output var eci_enc_t [ECI_NCH-1:0] enc,  // Encoder pins
	output var logic [ECI_NDIN-1:0]    din   // Trigger pins
);
	// Pins rest low; no pull, so levels are only what we set
	initial
	begin
		enc = '0;
		din = '0;
	end

	// Gray steps 00-01-11-10 forward; gaps let the counter settle
	task automatic step(input int ch, input logic up, input int n);
		repeat (n)
		begin
			@(posedge pclk);
			if (up)
				enc[ch].ab <= {enc[ch].ab[0], ~enc[ch].ab[1]};
			else
				enc[ch].ab <= {~enc[ch].ab[0], enc[ch].ab[1]};
			repeat (3) @(posedge pclk);
		end
	endtask

	// Index pulse, wide enough for any sampling
	task automatic index(input int ch);
		@(posedge pclk);
		enc[ch].idx <= 1'b1;
		repeat (3) @(posedge pclk);
		enc[ch].idx <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask

	// Pin level change, then wait out the two-flop synchroniser
	task automatic pin(input int i, input logic v);
		@(posedge pclk);
		din[i] <= v;
		repeat (6) @(posedge pclk);
	endtask
endmodule // eci_enc_model
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the four-channel encoder counter block
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import eci_pkg::*;
	typedef struct {
		int          ch;
		logic [1:0]  mode;
		logic [23:0] pre;
		logic [23:0] start;
		logic        up;
		int          n;
		logic [23:0] exp;
	} eci_row_t;
	logic                   pclk;
	logic                   presetn;
	logic                   psel;
	logic                   penable;
	logic                   pwrite;
	logic [11:0]            paddr;
	logic [31:0]            pwdata;
	logic [31:0]            prdata;
	logic                   pready;
	logic                   pslverr;
	eci_enc_t [ECI_NCH-1:0] enc;
	logic [ECI_NDIN-1:0]    din;
	logic                   irq;
	logic [ECI_NCH-1:0]     trig_out;
	logic [31:0]            r;
	logic                   perr;
	logic [11:0]            b;
	int                     n_errors;
	int                     total_checks;
	int                     n_trig;
	eci_row_t rows [7] = '{
		'{0, 2'h0, 24'h000005, 24'hFFFFFE, 1'b1, 3, 24'h000001},
		'{1, 2'h0, 24'h000005, 24'h000001, 1'b0, 3, 24'hFFFFFE},
		'{2, 2'h1, 24'h000005, 24'h000003, 1'b1, 4, 24'h000005},
		'{3, 2'h2, 24'h000005, 24'h000002, 1'b0, 4, 24'h000000},
		'{0, 2'h2, 24'h000005, 24'hFFFFFE, 1'b1, 3, 24'hFFFFFF},
		'{1, 2'h3, 24'h000005, 24'h000004, 1'b1, 3, 24'h000001},
		'{2, 2'h3, 24'h000005, 24'h000001, 1'b0, 3, 24'h000004}};

	eci_top eci_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .enc(enc), .din(din), .irq(irq),
		.trig_out(trig_out));
	eci_enc_model eci_enc_model_inst (.pclk(pclk), .enc(enc), .din(din));

	// 50 MHz clock
	always #10 pclk = ~pclk;

	// Match pulses on channel 0, counted to catch doubles
	always @(posedge pclk)
		if (trig_out[0] === 1'b1)
			n_trig <= n_trig + 1;

	task automatic chk(input string nm, input logic [31:0] s, e);
		total_checks++;
		if (s !== e)
		begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, e, s);
		end
	endtask

	// APB transfer; wait on pready bounded, so a dead slave is an error
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 16)
			n_errors++;
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		apb(1'b0, a, 32'h00000000, q);
	endtask

	task automatic expc(input logic [23:0] e);
		rd(ECI_CNT_OFS, r);
		chk("count0", r, {8'h00, e});
	endtask

	task automatic expl(input logic [23:0] e);
		rd(ECI_LAT_OFS, r);
		chk("latch0", r, {8'h00, e});
	endtask

	task automatic print_verdict;
		$display("checks %0d, errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Watchdog well beyond the expected run
	initial
	begin
		#(20 * 20000);
		n_errors++;
		print_verdict();
	end

	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		n_errors = 0;
		total_checks = 0;
		n_trig = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// Counter modes across channels, seven rows sharing the four channels
		foreach (rows[k])
		begin
			b = 12'(rows[k].ch * 16);
			wr(b + ECI_PRE_OFS, {8'h00, rows[k].pre});
			wr(b, {24'h000000, 6'h03, rows[k].mode});
			wr(b + ECI_CNT_OFS, {8'h00, rows[k].start});
			eci_enc_model_inst.step(rows[k].ch, rows[k].up, rows[k].n);
			rd(b + ECI_CNT_OFS, r);
			chk("count", r, {8'h00, rows[k].exp});
		end
		// Preset-on-index on the other channels, preset left at 5
		for (int c = 1; c < ECI_NCH; c++)
		begin
			b = 12'(c * 16);
			wr(b, 32'h0000005C);
			eci_enc_model_inst.index(c);
			rd(b + ECI_CNT_OFS, r);
			chk("index preset", r, 32'h00000005);
		end
		// Mode change by read-modify-write keeps the other bits
		wr(ECI_CTRL_OFS, 32'h000000DC);
		rd(ECI_CTRL_OFS, r);
		wr(ECI_CTRL_OFS, (r & 32'hFFFFFFFC) | 32'h00000002);
		rd(ECI_CTRL_OFS, r);
		chk("ctrl0", r, 32'h000000DE);
		// Master count enable off freezes the counter
		wr(ECI_CTRL_OFS, 32'h00000004);
		wr(ECI_CNT_OFS, 32'h0000000A);
		eci_enc_model_inst.step(0, 1'b1, 2);
		expc(24'h00000A);
		wr(ECI_CTRL_OFS, 32'h0000000C);
		eci_enc_model_inst.step(0, 1'b1, 2);
		expc(24'h00000C);
		// Index ignored, then clears, then presets
		eci_enc_model_inst.index(0);
		expc(24'h00000C);
		wr(ECI_CTRL_OFS, 32'h0000001C);
		eci_enc_model_inst.index(0);
		expc(24'h000000);
		wr(ECI_PRE_OFS, 32'h00000123);
		wr(ECI_CTRL_OFS, 32'h0000005C);
		eci_enc_model_inst.index(0);
		expc(24'h000123);
		rd(ECI_STS_OFS, r);
		chk("sts index", r & 32'h00000010, 32'h00000010);
		// Match-armed index: acts once after a match, then disarmed
		wr(ECI_CTRL_OFS, 32'h0000002C);
		wr(ECI_MAT_OFS, 32'h00000003);
		wr(ECI_CNT_OFS, 32'h00000001);
		eci_enc_model_inst.index(0);
		expc(24'h000001);
		eci_enc_model_inst.step(0, 1'b1, 3);
		eci_enc_model_inst.index(0);
		expc(24'h000000);
		eci_enc_model_inst.step(0, 1'b1, 2);
		eci_enc_model_inst.index(0);
		expc(24'h000002);
		// Match event: status, trigger pulse, interrupt, mask, clear
		wr(ECI_STS_OFS, 32'h000000FF);
		wr(ECI_MSK_OFS, 32'h00000001);
		wr(ECI_MAT_OFS, 32'h00000005);
		wr(ECI_CNT_OFS, 32'h00000004);
		n_trig = 0;
		eci_enc_model_inst.step(0, 1'b1, 1);
		// Match pulse, then trigger and status a cycle each behind
		repeat (3) @(posedge pclk);
		chk("trig pulses", 32'(n_trig), 32'h00000001);
		chk("irq", {31'h0, irq}, 32'h00000001);
		wr(ECI_STS_OFS, 32'h00000001);
		chk("irq cleared", {31'h0, irq}, 32'h00000000);
		wr(ECI_MSK_OFS, 32'h00000000);
		wr(ECI_CNT_OFS, 32'h00000004);
		eci_enc_model_inst.step(0, 1'b1, 1);
		rd(ECI_STS_OFS, r);
		chk("sts match", r & 32'h00000001, 32'h00000001);
		chk("irq masked", {31'h0, irq}, 32'h00000000);
		// Pin triggers: pin 3 rising, pin 5 falling, pin 2 disabled
		wr(ECI_CTRL_OFS, 32'h0000008C);
		wr(ECI_DIN_OFS, 32'h00000828);
		wr(ECI_CNT_OFS, 32'h00000007);
		eci_enc_model_inst.pin(3, 1'b1);
		expl(24'h000007);
		wr(ECI_CNT_OFS, 32'h00000008);
		eci_enc_model_inst.pin(3, 1'b0);
		eci_enc_model_inst.pin(5, 1'b1);
		expl(24'h000007);
		wr(ECI_CNT_OFS, 32'h00000009);
		eci_enc_model_inst.pin(5, 1'b0);
		expl(24'h000009);
		wr(ECI_CNT_OFS, 32'h0000000A);
		// Every disabled pin pulsed, none may capture
		for (int p = 0; p < ECI_NDIN; p++)
			if (p != 3 && p != 5)
			begin
				eci_enc_model_inst.pin(p, 1'b1);
				eci_enc_model_inst.pin(p, 1'b0);
			end
		expl(24'h000009);
		// Capture disabled leaves the latch alone
		wr(ECI_CTRL_OFS, 32'h0000000C);
		wr(ECI_SWT_OFS, 32'h00000001);
		expl(24'h000009);
		wr(ECI_CTRL_OFS, 32'h0000008C);
		wr(ECI_SWT_OFS, 32'h00000001);
		expl(24'h00000A);
		// Out of map or unaligned: refused, reads zero, write lost
		rd(12'h060, r);
		chk("unmapped data", r, 32'h00000000);
		chk("unmapped err", {31'h0, perr}, 32'h00000001);
		wr(12'h002, 32'h000000FF);
		chk("unaligned err", {31'h0, perr}, 32'h00000001);
		rd(ECI_CTRL_OFS, r);
		chk("ctrl0 kept", r, 32'h0000008C);
		// Second reset mid-run restores reset values
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(ECI_CTRL_OFS, r);
		chk("ctrl0 rst", r, {24'h000000, ECI_CTRL_RST});
		rd(ECI_PRE_OFS, r);
		chk("preset0 rst", r, {8'h00, ECI_PRE_RST});
		expl(24'h000000);
		chk("irq rst", {31'h0, irq}, 32'h00000000);
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
